// File: include/dws_pkg.sv
/*
  Shared constants and types of the dual wiper setting control block.
  Assumes the two-wire bus runs far slower than ref_clk (at most 400 kHz).
*/
package dws_pkg;

  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int          CHANNELS     = 2;
  localparam int          SAVED_PER_CH = 4;
  localparam int          WIPER_W      = 6;
  localparam int          TAPS         = 64;
  localparam logic [5:0]  WIPER_MIN    = 6'h00;
  localparam logic [5:0]  WIPER_MAX    = 6'h3f;
  localparam logic [5:0]  SAVED_RESET  = 6'h00;
  localparam logic [63:0] TAP_ZERO     = 64'h0000_0000_0000_0001;

  // ---------------------------------------------------------------
  // Serial framing
  // ---------------------------------------------------------------
  // Fixed upper nibble of the slave address byte; arbitrary value
  localparam logic [3:0] DEV_TYPE      = 4'h5;
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam int         INSTR_OP_LSB  = 4;
  localparam int         INSTR_CH_BIT  = 2;
  localparam int         INSTR_IDX_LSB = 0;

  typedef enum logic [3:0] {
    OP_INCDEC   = 4'h2,
    OP_RD_WIPER = 4'h9,
    OP_WR_WIPER = 4'ha,
    OP_RD_SAVED = 4'hb,
    OP_WR_SAVED = 4'hc,
    OP_RECALL   = 4'hd,
    OP_SAVE     = 4'he
  } dws_op_t;

  // Gray along ADDR -> INSTR -> DATA
  typedef enum logic [1:0] {
    PH_ADDR   = 2'h0,
    PH_INSTR  = 2'h1,
    PH_DATA   = 2'h3,
    PH_IGNORE = 2'h2
  } dws_phase_t;

  // Gray along INIT -> IDLE -> START -> FRAME
  typedef enum logic [1:0] {
    CORE_INIT  = 2'h0,
    CORE_IDLE  = 2'h1,
    CORE_START = 2'h3,
    CORE_FRAME = 2'h2
  } dws_core_t;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int FRAME_RST_NS  = 200;
  localparam int FRAME_RST_CYC = (FRAME_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : dws_pkg

// File: include/dws_link_if.sv
/*
  Carrier between the ref_clk core and the SCL-clocked serial slave.
  Assumes command fields stay stable while their toggle crosses domains.
*/
`timescale 1ns/1ps
interface dws_link_if import dws_pkg::*; ();
  logic       frame_rst;
  logic [3:0] dev_addr;
  logic [5:0] rd_data;
  logic       wr_tog;
  logic       rd_tog;
  dws_op_t    op;
  logic       chan;
  logic [1:0] idx;
  logic [5:0] data;
  logic       step_up;

  modport slave (input frame_rst, dev_addr, rd_data,
                 output wr_tog, rd_tog, op, chan, idx, data, step_up);
  modport core  (output frame_rst, dev_addr, rd_data,
                 input wr_tog, rd_tog, op, chan, idx, data, step_up);
endinterface : dws_link_if

// File: rtl/dws_serial_slave.sv
/*
  Serial slave on the SCL clock: shifts bytes, decodes address and
  instruction, drives ACK and read data. Assumes the core holds frame_rst
  high outside frames and releases it while SCL is high after a START.
*/
`timescale 1ns/1ps
module dws_serial_slave import dws_pkg::*; (
  input  wire logic scl,
  input  wire logic sda_i,
  output logic      sda_oe,
  dws_link_if.slave link
);

  typedef struct packed {
    dws_phase_t phase;
    logic [3:0] bit_cnt;
    logic [7:0] shreg;
    logic       ack;
    logic       wr_tog;
    logic       rd_tog;
    dws_op_t    op;
    logic       chan;
    logic [1:0] idx;
    logic [5:0] data;
    logic       step_up;
    logic       step_pend;
    logic       step_val;
  } dws_slv_t;

  dws_slv_t   st;
  dws_slv_t   next_st;
  logic [7:0] byte_in;
  logic [7:0] tx_shift;
  logic       is_read;
  logic       next_drive;

  assign is_read  = (st.op == OP_RD_WIPER) || (st.op == OP_RD_SAVED);
  assign byte_in  = {st.shreg[6:0], sda_i};
  assign tx_shift = {2'h0, link.rd_data} << st.bit_cnt[2:0];

  always_comb begin
    dws_op_t new_op;
    new_op  = dws_op_t'(byte_in[INSTR_OP_LSB +: 4]);
    next_st = st;
    // A step waits for the next SCL rise, so the rise of a STOP never steps
    if (st.step_pend) begin
      next_st.step_up   = st.step_val;
      next_st.wr_tog    = ~st.wr_tog;
      next_st.step_pend = 1'b0;
    end
    if (st.bit_cnt == BYTE_BITS) begin
      next_st.bit_cnt = 4'h0;
      // Controller NACK ends a read
      if (st.phase == PH_DATA && is_read && sda_i) begin
        next_st.phase = PH_IGNORE;
      end
    end else begin
      next_st.shreg   = byte_in;
      next_st.bit_cnt = st.bit_cnt + 4'h1;
      if (st.phase == PH_DATA && st.op == OP_INCDEC) begin
        next_st.step_val  = sda_i;
        next_st.step_pend = 1'b1;
      end
      if (st.bit_cnt == BYTE_BITS - 4'h1) begin
        next_st.ack = 1'b1;
        case (st.phase)
          PH_ADDR: begin
            if (byte_in == {DEV_TYPE, link.dev_addr}) begin
              next_st.phase = PH_INSTR;
            end else begin
              next_st.phase = PH_IGNORE;
              next_st.ack   = 1'b0;
            end
          end
          PH_INSTR: begin
            next_st.op    = new_op;
            next_st.chan  = byte_in[INSTR_CH_BIT];
            next_st.idx   = byte_in[INSTR_IDX_LSB +: 2];
            next_st.phase = PH_DATA;
            if (new_op == OP_RD_WIPER || new_op == OP_RD_SAVED) begin
              next_st.rd_tog = ~st.rd_tog;
            end
            if (new_op == OP_SAVE || new_op == OP_RECALL) begin
              next_st.wr_tog = ~st.wr_tog;
            end
          end
          PH_DATA: begin
            if (st.op == OP_WR_WIPER || st.op == OP_WR_SAVED) begin
              next_st.data   = byte_in[5:0];
              next_st.wr_tog = ~st.wr_tog;
            end
            if (is_read) begin
              next_st.ack = 1'b0;
            end
          end
          default: next_st.ack = 1'b0;
        endcase
      end
    end
  end

  // Data is sampled on the rising SCL edge only
  always_ff @(posedge scl or posedge link.frame_rst) begin
    if (link.frame_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    next_drive = 1'b0;
    if (st.bit_cnt == BYTE_BITS) begin
      next_drive = st.ack;
    end else if (st.phase == PH_DATA && is_read) begin
      next_drive = ~tx_shift[7];
    end
  end

  // Falling edge keeps SDA changes inside the SCL low phase; drive is low only
  always_ff @(negedge scl or posedge link.frame_rst) begin
    if (link.frame_rst) begin
      sda_oe <= 1'b0;
    end else begin
      sda_oe <= next_drive;
    end
  end

  assign link.wr_tog  = st.wr_tog;
  assign link.rd_tog  = st.rd_tog;
  assign link.op      = st.op;
  assign link.chan    = st.chan;
  assign link.idx     = st.idx;
  assign link.data    = st.data;
  assign link.step_up = st.step_up;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  addr_mismatch_a: assert property (@(posedge scl) disable iff (link.frame_rst)
    (st.phase == PH_ADDR && st.bit_cnt == 4'h7 && byte_in != {DEV_TYPE, link.dev_addr})
    |=> st.phase == PH_IGNORE ##1 st.phase == PH_IGNORE)
    else $error("Mismatched address not ignored");
  ignore_quiet_a: assert property (@(posedge scl) disable iff (link.frame_rst)
    (st.phase == PH_IGNORE && st.bit_cnt == BYTE_BITS) |-> !sda_oe)
    else $error("SDA driven while not addressed");
  bit_range_a: assert property (@(posedge scl) disable iff (link.frame_rst)
    st.bit_cnt <= BYTE_BITS)
    else $error("Bit counter out of range");
  addr_hit_c: cover property (@(posedge scl) disable iff (link.frame_rst)
    st.phase == PH_ADDR ##1 st.phase == PH_INSTR);

endmodule : dws_serial_slave

// File: rtl/dws_top.sv
/*
  Dual 64-tap wiper setting control: wiper and saved-setting registers,
  power-up recall, serial command execution and tap decode.
  Assumes SCL is supplied by the controller and the address pins are
  strapped (pads pull floating pins low).
*/
// Notes on behaviour
// - Each channel has its own volatile 6-bit wiper setting register.
// - Each channel has four 6-bit saved settings, eight in total.
// - After power-up each wiper loads its channel's first saved setting.
// - Exactly one of 64 taps per channel is selected by its wiper.
// - Bus address comes from four select inputs, bit0 least; floating reads zero.
// - Device answers only when address bits match the select inputs.
// - SDA is only ever pulled low, open-drain style.
// - Every transfer is clocked by the controller's serial clock only.
// - Wiper and saved settings can be read and written over the bus.
// - Instructions copy between a wiper and its own saved settings.
// - Increment/decrement mode steps the wiper up or down.
`timescale 1ns/1ps
module dws_top import dws_pkg::*; #(
  parameter logic [5:0] SAVED_INIT = SAVED_RESET
) (
  input  wire logic                 ref_clk,
  input  wire logic                 rstn,
  input  wire logic                 scl,
  input  wire logic                 sda_i,
  input  wire logic                 addr_select_bit0,
  input  wire logic                 addr_select_bit1,
  input  wire logic                 addr_select_bit2,
  input  wire logic                 addr_select_bit3,
  output logic                      sda_o,
  output logic                      sda_oe,
  output logic [1:0][5:0]           wiper_setting_reg,
  output logic [1:0][63:0]          tap_select
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    dws_core_t            phase;
    logic [2:0]           scl_s;
    logic [2:0]           sda_s;
    logic [2:0]           wr_s;
    logic [2:0]           rd_s;
    logic [2:0][3:0]      addr_s;
    logic                 scl_f;
    logic                 sda_f;
    logic                 wr_f;
    logic                 rd_f;
    logic [3:0]           addr_f;
    logic [2:0]           cnt;
    logic                 frame_rst;
    logic [1:0][5:0]      wiper;
    logic [1:0][3:0][5:0] saved;
    logic [1:0][63:0]     tap;
    logic [5:0]           rd_data;
    logic                 sda_o;
  } dws_core_state_t;

  dws_core_state_t st;
  dws_core_state_t next_st;
  logic            start_evt;
  logic            stop_evt;
  logic            wr_evt;
  logic            rd_evt;
  logic [3:0]      addr_pins;

  dws_link_if link ();

  assign addr_pins = {addr_select_bit3, addr_select_bit2, addr_select_bit1, addr_select_bit0};

  dws_serial_slave u_slave (
    .scl    (scl),
    .sda_i  (sda_i),
    .sda_oe (sda_oe),
    .link   (link.slave)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    // Three-stage sync; a change counts once stages two and three agree
    next_st.scl_s  = {st.scl_s[1:0], scl};
    next_st.sda_s  = {st.sda_s[1:0], sda_i};
    next_st.wr_s   = {st.wr_s[1:0], link.wr_tog};
    next_st.rd_s   = {st.rd_s[1:0], link.rd_tog};
    next_st.addr_s = {st.addr_s[1:0], addr_pins};
    next_st.scl_f  = (st.scl_s[1] & st.scl_s[2]) | (st.scl_f & (st.scl_s[1] | st.scl_s[2]));
    next_st.sda_f  = (st.sda_s[1] & st.sda_s[2]) | (st.sda_f & (st.sda_s[1] | st.sda_s[2]));
    next_st.wr_f   = (st.wr_s[1] & st.wr_s[2]) | (st.wr_f & (st.wr_s[1] | st.wr_s[2]));
    next_st.rd_f   = (st.rd_s[1] & st.rd_s[2]) | (st.rd_f & (st.rd_s[1] | st.rd_s[2]));
    next_st.addr_f = (st.addr_s[1] & st.addr_s[2])
                   | (st.addr_f & (st.addr_s[1] | st.addr_s[2]));

    start_evt = st.scl_f & next_st.scl_f & st.sda_f & ~next_st.sda_f;
    stop_evt  = st.scl_f & next_st.scl_f & ~st.sda_f & next_st.sda_f;
    wr_evt    = (st.phase == CORE_FRAME) && (next_st.wr_f != st.wr_f);
    rd_evt    = (st.phase == CORE_FRAME) && (next_st.rd_f != st.rd_f);
    next_st.sda_o = 1'b0;

    case (st.phase)
      CORE_INIT: begin
        for (int c = 0; c < CHANNELS; c++) begin
          next_st.wiper[c] = st.saved[c][0];
        end
        next_st.phase = CORE_IDLE;
      end
      CORE_IDLE: begin
        next_st.frame_rst = 1'b1;
        if (start_evt) begin
          next_st.phase = CORE_START;
          next_st.cnt   = 3'h0;
        end
      end
      CORE_START: begin
        // Slave held cleared long enough to flush stale toggles
        next_st.frame_rst = 1'b1;
        next_st.cnt       = st.cnt + 3'h1;
        if (st.cnt == 3'(FRAME_RST_CYC - 1)) begin
          next_st.phase     = CORE_FRAME;
          next_st.frame_rst = 1'b0;
        end
      end
      CORE_FRAME: begin
        if (stop_evt) begin
          next_st.phase     = CORE_IDLE;
          next_st.frame_rst = 1'b1;
        end else if (start_evt) begin
          next_st.phase     = CORE_START;
          next_st.cnt       = 3'h0;
          next_st.frame_rst = 1'b1;
        end
      end
      default: next_st.phase = CORE_INIT;
    endcase

    // Toggles restart from zero with every frame reset
    if (st.phase != CORE_FRAME) begin
      next_st.wr_f = 1'b0;
      next_st.rd_f = 1'b0;
    end

    if (rd_evt) begin
      if (link.op == OP_RD_WIPER) begin
        next_st.rd_data = st.wiper[link.chan];
      end else begin
        next_st.rd_data = st.saved[link.chan][link.idx];
      end
    end

    if (wr_evt) begin
      case (link.op)
        OP_WR_WIPER: next_st.wiper[link.chan] = link.data;
        OP_WR_SAVED: next_st.saved[link.chan][link.idx] = link.data;
        OP_SAVE:     next_st.saved[link.chan][link.idx] = st.wiper[link.chan];
        OP_RECALL:   next_st.wiper[link.chan] = st.saved[link.chan][link.idx];
        OP_INCDEC: begin
          if (link.step_up && st.wiper[link.chan] != WIPER_MAX) begin
            next_st.wiper[link.chan] = st.wiper[link.chan] + 6'h01;
          end else if (!link.step_up && st.wiper[link.chan] != WIPER_MIN) begin
            next_st.wiper[link.chan] = st.wiper[link.chan] - 6'h01;
          end
        end
        default: next_st.wiper = st.wiper;
      endcase
    end

    // One-hot tap decode per channel
    for (int c = 0; c < CHANNELS; c++) begin
      next_st.tap[c] = TAP_ZERO << next_st.wiper[c];
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Saved settings model nonvolatile storage; reset stands in for power-up
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st           <= '0;
      st.phase     <= CORE_INIT;
      st.frame_rst <= 1'b1;
      st.saved     <= {(CHANNELS * SAVED_PER_CH){SAVED_INIT}};
      st.tap       <= {CHANNELS{TAP_ZERO}};
    end else begin
      st <= next_st;
    end
  end

  assign link.frame_rst  = st.frame_rst;
  assign link.dev_addr   = st.addr_f;
  assign link.rd_data    = st.rd_data;
  assign sda_o           = st.sda_o;
  assign wiper_setting_reg = st.wiper;
  assign tap_select      = st.tap;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  recall_init_a: assert property (
    st.phase == CORE_INIT |=> (wiper_setting_reg[0] == $past(st.saved[0][0]))
                           && (wiper_setting_reg[1] == $past(st.saved[1][0])))
    else $error("Power-up recall did not load first saved setting");
  tap_onehot_a: assert property (
    $onehot(tap_select[0]) && $onehot(tap_select[1]))
    else $error("Tap select is not one-hot");
  tap_follows_a: assert property (
    st.phase != CORE_INIT |-> tap_select[0][wiper_setting_reg[0]]
                           && tap_select[1][wiper_setting_reg[1]])
    else $error("Tap does not follow wiper setting");
  sda_low_only_a: assert property (sda_o == 1'b0)
    else $error("SDA output level not low");
  frame_gate_a: assert property (
    (st.phase != CORE_FRAME) |-> link.frame_rst)
    else $error("Slave released outside a frame");
  addr_sync_a: assert property (
    $stable(addr_pins) [*4] |=> link.dev_addr == $past(addr_pins, 2))
    else $error("Device address does not follow select inputs");
  wr_wiper_a: assert property (
    (wr_evt && link.op == OP_WR_WIPER)
    |=> wiper_setting_reg[$past(link.chan)] == $past(link.data))
    else $error("Wiper write lost");
  save_a: assert property (
    (wr_evt && link.op == OP_SAVE)
    |=> st.saved[$past(link.chan)][$past(link.idx)] == $past(st.wiper[link.chan]))
    else $error("Save to saved setting lost");
  recall_a: assert property (
    (wr_evt && link.op == OP_RECALL)
    |=> st.wiper[$past(link.chan)] == $past(st.saved[link.chan][link.idx]))
    else $error("Recall from saved setting lost");
  inc_step_a: assert property (
    (wr_evt && link.op == OP_INCDEC && link.step_up && st.wiper[link.chan] != WIPER_MAX)
    |=> st.wiper[$past(link.chan)] == $past(st.wiper[link.chan]) + 6'h01)
    else $error("Increment step wrong");
  sat_high_a: assert property (
    (wr_evt && link.op == OP_INCDEC && link.step_up && st.wiper[link.chan] == WIPER_MAX)
    |=> st.wiper[$past(link.chan)] == WIPER_MAX)
    else $error("Wiper wrapped above top tap");
  sat_low_a: assert property (
    (wr_evt && link.op == OP_INCDEC && !link.step_up && st.wiper[link.chan] == WIPER_MIN)
    |=> st.wiper[$past(link.chan)] == WIPER_MIN)
    else $error("Wiper wrapped below bottom tap");

  dec_step_a: assert property (
    (wr_evt && link.op == OP_INCDEC && !link.step_up && st.wiper[link.chan] != WIPER_MIN)
    |=> st.wiper[$past(link.chan)] == $past(st.wiper[link.chan]) - 6'h01)
    else $error("Decrement step wrong");

  wr_saved_a: assert property (
    (wr_evt && link.op == OP_WR_SAVED)
    |=> st.saved[$past(link.chan)][$past(link.idx)] == $past(link.data))
    else $error("Saved write lost");

  rd_wiper_a: assert property (
    (rd_evt && link.op == OP_RD_WIPER)
    |=> link.rd_data == $past(st.wiper[link.chan]))
    else $error("Wiper read data wrong");

  rd_saved_a: assert property (
    (rd_evt && link.op == OP_RD_SAVED)
    |=> link.rd_data == $past(st.saved[link.chan][link.idx]))
    else $error("Saved read data wrong");

  chan_apart_a: assert property (
    (wr_evt && link.op == OP_WR_WIPER)
    |=> st.wiper[!$past(link.chan)] == $past(st.wiper[!link.chan]))
    else $error("Write disturbed other channel");

  saved_hold_a: assert property (
    !wr_evt |=> st.saved == $past(st.saved))
    else $error("Saved setting changed alone");

  wiper_hold_a: assert property (
    (st.phase != CORE_INIT && !wr_evt) |=> st.wiper == $past(st.wiper))
    else $error("Wiper changed alone");

  frame_len_a: assert property (
    $fell(link.frame_rst) |-> $past(st.cnt) == 3'(FRAME_RST_CYC - 1))
    else $error("Slave released too early");

  stop_idle_a: assert property (
    (st.phase == CORE_FRAME && stop_evt) |=> link.frame_rst)
    else $error("Frame not closed by stop");

  rst_quiet_a: assert property (
    link.frame_rst |-> !sda_oe)
    else $error("SDA driven outside a frame");

  wr_wiper_c: cover property (wr_evt && link.op == OP_WR_WIPER);
  incdec_c:   cover property (wr_evt && link.op == OP_INCDEC);
  save_c:     cover property (wr_evt && link.op == OP_SAVE);
  read_c:     cover property (rd_evt);

endmodule : dws_top

// File: tb/dws_bus_ctrl.sv
/*
  Behavioural two-wire bus controller that stands opposite the device.
  Assumes SDA is resolved outside with a pull-up, and SCL rests high between frames.
*/
`timescale 1ns/1ps
module dws_bus_ctrl (
  input  wire logic ref_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      pull_low
);
  // Half SCL period in ref_clk cycles, 400 kHz at 20 MHz
  localparam int HALF = 25;

  initial begin
    scl      = 1'b1;
    pull_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // ---------------------------------------------------------------
  // Framing
  // ---------------------------------------------------------------
  // Also serves as repeated START: releases SDA before raising SCL
  task automatic start();
    tick(2);
    pull_low <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    pull_low <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    tick(2);
    pull_low <= 1'b1;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    pull_low <= 1'b0;
    tick(HALF);
  endtask : stop

  // ---------------------------------------------------------------
  // Bits and bytes
  // ---------------------------------------------------------------
  task automatic put_bit(input logic b);
    tick(2);
    pull_low <= !b;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF);
    scl <= 1'b0;
  endtask : put_bit

  task automatic get_bit(output logic b);
    tick(2);
    pull_low <= 1'b0;
    tick(HALF);
    scl <= 1'b1;
    tick(HALF / 2);
    b = sda;
    tick(HALF - HALF / 2);
    scl <= 1'b0;
  endtask : get_bit

  // Address byte carries the strap levels chosen by the caller
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = !b;
  endtask : send_byte

  task automatic recv_byte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(!more);
  endtask : recv_byte
endmodule : dws_bus_ctrl

// File: tb/tb_dual_wiper_setting_control.sv
/*
  Self-checking bench of the dual wiper setting control block.
  Assumes dws_bus_ctrl drives the bus; SDA is pulled up when nobody pulls it.
*/
`timescale 1ns/1ps
module tb_dual_wiper_setting_control import dws_pkg::*; ();
  localparam logic [5:0] INIT_VAL = 6'h15;
  logic                  ref_clk, rstn, scl, sda, sda_o, sda_oe, pull_low;
  logic [3:0]            addr;
  logic [1:0][5:0]       wiper;
  logic [1:0][63:0]      tap;
  logic [5:0]            mw [2];
  logic [5:0]            ms [2][4];
  logic [63:0]           exp_q [$];
  logic [63:0]           obs_val, e_val;
  string                 obs_nm;
  bit                    obs_pin;
  event                  obs_ev;
  int                    err_count, n_checks;
  int                    seed = 32'h64be;

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Open-drain wire: low if either party pulls
  assign sda = !(pull_low || (sda_oe && !sda_o));

  dws_top #(.SAVED_INIT(INIT_VAL)) DUT (
    .ref_clk(ref_clk), .rstn(rstn), .scl(scl), .sda_i(sda),
    .addr_select_bit0(addr[0]), .addr_select_bit1(addr[1]),
    .addr_select_bit2(addr[2]), .addr_select_bit3(addr[3]),
    .sda_o(sda_o), .sda_oe(sda_oe), .wiper_setting_reg(wiper), .tap_select(tap));

  dws_bus_ctrl ctrl (.ref_clk(ref_clk), .sda(sda), .scl(scl), .pull_low(pull_low));

  // ---------------------------------------------------------------
  // Checking
  // ---------------------------------------------------------------
  task automatic cmp_bus(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_checks++;
    if (got !== ex) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask : cmp_bus

  task automatic cmp_pin(input string nm, input logic [63:0] ex, input logic [63:0] got);
    n_checks++;
    if (got !== ex) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask : cmp_pin

  always @(obs_ev) begin
    e_val = exp_q.pop_front();
    if (obs_pin) cmp_pin(obs_nm, e_val, obs_val);
    else cmp_bus(obs_nm, e_val[7:0], obs_val[7:0]);
  end

  task automatic note(input bit pin, input string nm, input logic [63:0] ex,
                      input logic [63:0] got);
    exp_q.push_back(ex);
    obs_pin = pin;
    obs_nm  = nm;
    obs_val = got;
    ->obs_ev;
    #1;
  endtask : note

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------
  // Bus operations
  // ---------------------------------------------------------------
  task automatic cmd(input logic [7:0] ab, input dws_op_t op, input logic ch,
                     input logic [1:0] ix, input int nd, input logic [7:0] d, input logic ea);
    logic a;
    ctrl.start();
    ctrl.send_byte(ab, a);
    note(0, "addr ack", 64'(ea), 64'(a));
    if (ea) begin
      ctrl.send_byte({op, 1'b0, ch, ix}, a);
      note(0, "instr ack", 64'h1, 64'(a));
      repeat (nd) begin
        ctrl.send_byte(d, a);
        note(0, "data ack", 64'h1, 64'(a));
      end
    end
    ctrl.stop();
  endtask : cmd

  task automatic rd(input dws_op_t op, input logic ch, input logic [1:0] ix, input logic [5:0] ex);
    logic       a;
    logic [7:0] d;
    ctrl.start();
    ctrl.send_byte({DEV_TYPE, addr}, a);
    ctrl.send_byte({op, 1'b0, ch, ix}, a);
    ctrl.recv_byte(1'b0, d);
    ctrl.stop();
    note(0, "read byte", 64'({2'b00, ex}), 64'(d));
  endtask : rd

  task automatic pins();
    for (int c = 0; c < 2; c++) begin
      note(1, "wiper", 64'(mw[c]), 64'(wiper[c]));
      note(1, "tap", TAP_ZERO << mw[c], tap[c]);
    end
  endtask : pins

  function automatic logic [5:0] step(input logic [5:0] w, input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      if (b[i]) w = (w == WIPER_MAX) ? w : w + 6'h01;
      else w = (w == WIPER_MIN) ? w : w - 6'h01;
    end
    return w;
  endfunction : step

  initial begin
    repeat (99000) @(posedge ref_clk);
    err_count++;
    $display("FAIL watchdog expected end seen hang");
    summarize();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    logic [7:0] d;
    logic       ch;
    rstn = 1'b0;
    addr = 4'h0;
    for (int c = 0; c < 8; c++) begin
      mw[c / 4]        = INIT_VAL;
      ms[c / 4][c % 4] = INIT_VAL;
    end
    repeat (5) @(posedge ref_clk);
    addr <= 4'($random(seed));
    rstn <= 1'b1;
    repeat (10) @(posedge ref_clk);
    pins();
    $display("test recall done");
    for (int i = 0; i < 4; i++) begin
      d  = (i == 0) ? 8'hc0 : (i == 1) ? 8'h3f : 8'($random(seed));
      ch = i[0];
      cmd({DEV_TYPE, addr}, OP_WR_WIPER, ch, 2'h0, 1, d, 1'b1);
      mw[ch] = d[5:0];
      pins();
      rd(OP_RD_WIPER, ch, 2'h0, mw[ch]);
    end
    $display("test wiper done");
    cmd({DEV_TYPE, addr ^ 4'h1}, OP_WR_WIPER, 1'b0, 2'h0, 1, 8'h2a, 1'b0);
    cmd({DEV_TYPE ^ 4'h8, addr}, OP_WR_WIPER, 1'b1, 2'h0, 1, 8'h2a, 1'b0);
    pins();
    $display("test address done");
    for (int c = 0; c < 8; c++) begin
      d = 8'($random(seed));
      cmd({DEV_TYPE, addr}, OP_WR_SAVED, c[2], c[1:0], 1, d, 1'b1);
      ms[c[2]][c[1:0]] = d[5:0];
    end
    for (int c = 0; c < 8; c++) rd(OP_RD_SAVED, c[2], c[1:0], ms[c[2]][c[1:0]]);
    for (int c = 0; c < 4; c++) begin
      cmd({DEV_TYPE, addr}, OP_RECALL, c[0], c[1:0], 0, 8'h00, 1'b1);
      mw[c[0]] = ms[c[0]][c[1:0]];
      pins();
    end
    for (int c = 0; c < 2; c++) begin
      d = {2'b00, ~ms[c][3]};
      cmd({DEV_TYPE, addr}, OP_WR_WIPER, c[0], 2'h0, 1, d, 1'b1);
      cmd({DEV_TYPE, addr}, OP_SAVE, c[0], 2'h3, 0, 8'h00, 1'b1);
      mw[c]    = d[5:0];
      ms[c][3] = d[5:0];
      rd(OP_RD_SAVED, c[0], 2'h3, ms[c][3]);
    end
    $display("test saved done");
    for (int i = 0; i < 3; i++) begin
      if (i != 1) begin
        d = (i == 0) ? 8'h3e : 8'h02;
        cmd({DEV_TYPE, addr}, OP_WR_WIPER, 1'b1, 2'h0, 1, d, 1'b1);
        mw[1] = d[5:0];
      end
      d = (i == 0) ? 8'hff : (i == 1) ? 8'($random(seed)) : 8'h0f;
      cmd({DEV_TYPE, addr}, OP_INCDEC, 1'b1, 2'h0, 1, d, 1'b1);
      mw[1] = step(mw[1], d);
      pins();
    end
    $display("test step done");
    summarize();
  end
endmodule : tb_dual_wiper_setting_control
